// [design/mgm_mem_map.v]
// Memory map, bus slave, calibration and comparator of the magnetometer.
// Assumes bus pins and ADC samples are synchronous to core_clk, and that
// the bus clock is far slower than core_clk so each edge is seen once.
`timescale 1ns/10ps
`include "mgm_defines.vh"
module mgm_mem_map #(
  parameter [7:0]  FERRITE_TC = 8'h14,          // Extra coefficient.
  parameter [7:0]  RARE_TC    = 8'h0c,          // Extra coefficient.
  parameter [47:0] LOT_CODE   = 48'h303030303030 // Arbitrary value.
) (
  input  wire       core_clk,     // System clock, 25 MHz.
  input  wire       rstn,         // Asynchronous reset, active low.
  input  wire       scl_i,        // Bus clock level.
  output reg        scl_o,        // Bus clock drive value, always low.
  output reg        scl_oe,       // Bus clock drive enable, never set.
  input  wire       sda_i,        // Bus data level.
  output reg        sda_o,        // Bus data drive value, always low.
  output reg        sda_oe,       // High while pulling data low.
  input  wire       strap_pin,    // Strap level, 1 when open or high.
  input  wire [7:0] strap_level,  // Strap voltage from the ADC.
  input  wire       sample_stb,   // New ADC samples are valid.
  input  wire [7:0] adc_field,    // Bridge sample.
  input  wire [7:0] adc_temp,     // Raw temperature, signed.
  output reg        cmp_out,      // Digital comparator output.
  output reg        pullup_en     // Enables internal bus pull-ups.
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RD   = 3'h5;
  localparam [2:0] ST_MACK = 3'h6;

  // Index of each stored parameter in the packed vectors below.
  localparam IX_THR   = 0;
  localparam IX_HYST  = 1;
  localparam IX_INV   = 2;
  localparam IX_FOFS  = 3;
  localparam IX_FGAIN = 4;
  localparam IX_TCO   = 5;
  localparam IX_TOFS  = 6;
  localparam IX_TGAIN = 7;
  localparam IX_FILT  = 8;
  localparam IX_PULL  = 9;
  localparam IX_PROF  = 10;

  localparam [8*`MGM_NV_N-1:0] NV_OFS = {
    `MGM_A_PROF, `MGM_A_PULL, `MGM_A_FILT, `MGM_A_TGAIN, `MGM_A_TOFS,
    `MGM_A_TCO, `MGM_A_FGAIN, `MGM_A_FOFS, `MGM_A_INV, `MGM_A_HYST,
    `MGM_A_THR};
  localparam [8*`MGM_NV_N-1:0] NV_DEF = {
    `MGM_D_PROF, `MGM_D_PULL, `MGM_D_FILT, `MGM_D_TGAIN, `MGM_D_TOFS,
    `MGM_D_TCO, `MGM_D_FGAIN, `MGM_D_FOFS, `MGM_D_INV, `MGM_D_HYST,
    `MGM_D_THR};

  reg         scl_q;
  reg         sda_q;
  reg  [2:0]  st_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  sh_q;
  reg  [7:0]  tx_q;
  reg         rw_q;
  reg         ph_q;
  reg         nack_q;
  reg  [7:0]  ptr_q;
  reg         wr_stb_q;
  reg  [7:0]  wr_dat_q;
  reg         init_q;
  reg         strap_q;
  reg  [7:0]  strapv_q;
  reg  [6:0]  busa_q;
  reg  [7:0]  raw_q;
  reg  [7:0]  traw_q;
  reg  [7:0]  filt_q;
  reg  [7:0]  temp_q;
  reg  [7:0]  cal_q;
  reg         cmp_q;
  reg  [7:0]  rd_byte;
  reg  [7:0]  filt_d;
  reg  [15:0] filt_w;
  reg  [7:0]  temp_d;
  reg  [7:0]  cal_d;
  reg         cmp_d;
  integer     i;

  wire [8*`MGM_NV_N-1:0] nv_val;
  wire [7:0] thr   = nv_val[8*IX_THR   +: 8];
  wire [7:0] hyst  = nv_val[8*IX_HYST  +: 8];
  wire [7:0] inv   = nv_val[8*IX_INV   +: 8];
  wire [7:0] fofs  = nv_val[8*IX_FOFS  +: 8];
  wire [7:0] fgain = nv_val[8*IX_FGAIN +: 8];
  wire [7:0] tco   = nv_val[8*IX_TCO   +: 8];
  wire [7:0] tofs  = nv_val[8*IX_TOFS  +: 8];
  wire [7:0] tgain = nv_val[8*IX_TGAIN +: 8];
  wire [7:0] fm    = nv_val[8*IX_FILT  +: 8];
  wire [7:0] pull  = nv_val[8*IX_PULL  +: 8];
  wire [7:0] prof  = nv_val[8*IX_PROF  +: 8];

  // Bus conditions, seen against the previous pin levels.
  wire rise  = ~scl_q & scl_i;
  wire fall  = scl_q & ~scl_i;
  wire start = scl_q & scl_i & sda_q & ~sda_i;
  wire stop  = scl_q & scl_i & ~sda_q & sda_i;

  wire wr_hit_cmp = wr_stb_q & (ptr_q == `MGM_A_CMP);
  wire restore = wr_stb_q & (wr_dat_q == `MGM_RESTORE_VAL) &
                 ((ptr_q == `MGM_A_RESTORE) |
                  (ptr_q == `MGM_A_RESTORE2));

  // Stored parameters; a write lands only on its own location.
  genvar g;
  generate
    for (g = 0; g < `MGM_NV_N; g = g + 1) begin : g_nv
      wire [7:0] ofs = NV_OFS[8*g +: 8];
      wire bad_thr  = (ofs == `MGM_A_THR) & (wr_dat_q == 8'h00);
      wire bad_prof = (ofs == `MGM_A_PROF) &
                      (wr_dat_q > `MGM_PROF_MAX);
      mgm_nv_byte #(
        .DEFAULT (NV_DEF[8*g +: 8])
      ) u_nv (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_en    (wr_stb_q & (ptr_q == ofs) & ~bad_thr & ~bad_prof),
        .restore  (restore),
        .wr_data  (wr_dat_q),
        .value_q  (nv_val[8*g +: 8])
      );
    end
  endgenerate

  // Read mux over the three regions; anything else reads as all ones.
  always @* begin
    rd_byte = `MGM_UNMAPPED;
    case (ptr_q)
      `MGM_A_CAL:     rd_byte = cal_q;
      `MGM_A_RAW:     rd_byte = raw_q;
      `MGM_A_TEMP:    rd_byte = temp_q;
      `MGM_A_CMP:     rd_byte = {7'h00, cmp_q};
      `MGM_A_STRAPV:  rd_byte = strapv_q;
      `MGM_A_RESTORE: rd_byte = 8'h00;
      `MGM_A_BUSADDR: rd_byte = {1'b0, busa_q};
      default:        rd_byte = `MGM_UNMAPPED;
    endcase
    for (i = 0; i < `MGM_NV_N; i = i + 1) begin
      if (ptr_q == NV_OFS[8*i +: 8]) begin
        rd_byte = nv_val[8*i +: 8];
      end
    end
    if ((ptr_q >= `MGM_A_LOT) && (ptr_q <= `MGM_A_LOT_LAST)) begin
      rd_byte = LOT_CODE[{ptr_q[2:0], 3'b000} +: 8];
    end
  end

  // Bus slave. It never drives the clock and only answers a master.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      st_q     <= ST_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      ph_q     <= 1'b0;
      nack_q   <= 1'b1;
      ptr_q    <= `MGM_A_CAL;
      wr_stb_q <= 1'b0;
      wr_dat_q <= 8'h00;
      sda_oe   <= 1'b0;
    end else begin
      scl_q    <= scl_i;
      sda_q    <= sda_i;
      wr_stb_q <= 1'b0;
      if (start) begin
        st_q   <= ST_ADDR;
        cnt_q  <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st_q   <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_WR: begin
            if (rise) begin
              sh_q  <= {sh_q[6:0], sda_i};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && (cnt_q == 4'h8)) begin
              if (st_q == ST_ADDR) begin
                if (sh_q[7:1] == busa_q) begin
                  sda_oe <= 1'b1;
                  rw_q   <= sh_q[0];
                  ph_q   <= 1'b0;
                  st_q   <= ST_AACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                st_q   <= ST_WACK;
                ph_q   <= ~ph_q;
                if (!ph_q) begin
                  ptr_q <= sh_q;
                end else begin
                  wr_stb_q <= 1'b1;
                  wr_dat_q <= sh_q;
                end
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (fall) begin
              cnt_q <= 4'h0;
              if ((st_q == ST_AACK) && rw_q) begin
                tx_q   <= rd_byte;
                sda_oe <= ~rd_byte[7];
                st_q   <= ST_RD;
              end else begin
                sda_oe <= 1'b0;
                st_q   <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe <= 1'b0;
                st_q   <= ST_MACK;
              end else begin
                tx_q   <= {tx_q[6:0], 1'b1};
                sda_oe <= ~tx_q[6];
              end
            end
          end
          ST_MACK: begin
            if (rise) begin
              nack_q <= sda_i;
            end else if (fall) begin
              if (nack_q) begin
                st_q <= ST_IDLE;
              end else begin
                // The pointer is left alone, so the same byte repeats.
                tx_q   <= rd_byte;
                sda_oe <= ~rd_byte[7];
                cnt_q  <= 4'h0;
                st_q   <= ST_RD;
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Strap capture on the first edge after reset, plus the slave address.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      init_q   <= 1'b0;
      strap_q  <= 1'b1;
      strapv_q <= `MGM_FULL_BYTE;
      busa_q   <= `MGM_ADDR_OPEN;
    end else if (!init_q) begin
      init_q   <= 1'b1;
      strap_q  <= strap_pin;
      strapv_q <= strap_level;
      busa_q   <= strap_pin ? `MGM_ADDR_OPEN : `MGM_ADDR_GND;
    end else if (restore) begin
      busa_q   <= strap_q ? `MGM_ADDR_OPEN : `MGM_ADDR_GND;
    end else if (wr_stb_q && (ptr_q == `MGM_A_BUSADDR) &&
                 !wr_dat_q[7] &&
                 (wr_dat_q[6:0] >= `MGM_ADDR_MIN)) begin
      busa_q   <= wr_dat_q[6:0];
    end
  end

  // Running average; the divide is combinational, which is why a new
  // sample is only taken on the strobe and never every cycle.
  always @* begin
    filt_w = ({8'h00, adc_field} +
              ({8'h00, fm - 8'h01} * {8'h00, filt_q})) /
             {8'h00, fm};
    if (fm <= 8'h01) begin
      filt_d = adc_field;
    end else begin
      filt_d = filt_w[7:0];
    end
  end

  // Temperature correction, clamped to the signed byte range.
  reg signed [15:0] t_s;
  always @* begin
    t_s = ($signed({{8{traw_q[7]}}, traw_q}) * $signed(`MGM_PCT_W)) /
          $signed({8'h00, (tgain == 8'h00) ? 8'h64 : tgain}) +
          $signed({{8{tofs[7]}}, tofs});
    if (t_s > 16'sd127) begin
      temp_d = 8'h7f;
    end else if (t_s < -16'sd128) begin
      temp_d = 8'h80;
    end else begin
      temp_d = t_s[7:0];
    end
  end

  // Field correction. Magnet profiles add to the coefficient; gain is a
  // percentage, so the result is scaled by 100 over the gain.
  reg        [9:0]  tc_eff;
  reg signed [39:0] num_s;
  reg signed [39:0] den_s;
  reg signed [39:0] cal_s;
  always @* begin
    case (prof)
      8'h01:   tc_eff = {2'b00, tco} + {2'b00, FERRITE_TC};
      8'h02:   tc_eff = {2'b00, tco} + {2'b00, RARE_TC};
      default: tc_eff = {2'b00, tco};
    endcase
    num_s = $signed({32'h0, filt_q}) * `MGM_PCT *
            ($signed(40'sd100000) +
             $signed({{32{temp_q[7]}}, temp_q}) *
             $signed({30'h0, tc_eff}));
    den_s = $signed(40'sd100000) *
            $signed({32'h0, (fgain == 8'h00) ? 8'h01 : fgain});
    cal_s = num_s / den_s - $signed({{32{fofs[7]}}, fofs});
    if (cal_s < 40'sd0) begin
      cal_d = 8'h00;
    end else if (cal_s > 40'sd255) begin
      cal_d = `MGM_FULL_BYTE;
    end else begin
      cal_d = cal_s[7:0];
    end
  end

  // Comparator with hysteresis; a rising field beats a clearing write.
  wire       latch_mode = (hyst == `MGM_LATCH_HYST) | (hyst >= thr);
  wire [7:0] lo_lim     = thr - hyst;
  always @* begin
    if (cal_q > thr) begin
      cmp_d = 1'b1;
    end else if (wr_hit_cmp) begin
      cmp_d = 1'b0;
    end else if (!latch_mode && (cal_q < lo_lim)) begin
      cmp_d = 1'b0;
    end else begin
      cmp_d = cmp_q;
    end
  end

  // Measurement registers and the pin-side outputs.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      raw_q     <= 8'h00;
      traw_q    <= 8'h00;
      filt_q    <= 8'h00;
      temp_q    <= 8'h00;
      cal_q     <= 8'h00;
      cmp_q     <= 1'b0;
      cmp_out   <= 1'b0;
      pullup_en <= 1'b1;
      sda_o     <= 1'b0;
      scl_o     <= 1'b0;
      scl_oe    <= 1'b0;
    end else begin
      if (sample_stb) begin
        raw_q  <= adc_field;
        traw_q <= adc_temp;
        filt_q <= filt_d;
      end
      temp_q    <= temp_d;
      cal_q     <= cal_d;
      cmp_q     <= cmp_d;
      cmp_out   <= cmp_q ^ inv[0];
      pullup_en <= pull[0];
      sda_o     <= 1'b0;
      scl_o     <= 1'b0;
      scl_oe    <= 1'b0;
    end
  end

endmodule // mgm_mem_map

// [pkg/mgm_defines.vh]
// Constants for the magnetometer memory map and its bus slave.
// Assumes the includer adds the pkg folder to its include path.
//
// Notes on behaviour
// - Calibrated field 100 is top of linear range; it keeps rising to 255.
// - Writing 1 to the restore location reloads every calibration parameter.
// - Device is only a bus slave, up to 400 kHz; master starts every transfer.
// - Seven-bit slave address stays within 8 to 127; 0 to 7 are reserved.
// - Slave address is a stored parameter, rewritable over the bus.
// - Strap sampled at power-up: open or high gives 72, grounded gives 16.
// - Master writes an address byte; later reads return the byte there.
// - The active address stays unchanged across successive reads.
// - After power-up the active address is zero, the calibrated field.
// - Unimplemented reads give 0xff; unimplemented writes change nothing. The code also restores on 1 written to 0x07, which reads 0xff.
// - Decode regions 0x00-0x0f data, 0x20-0x2f parameters, 0x80-0x8f constants.
// - Location 0x01 gives the uncorrected reading as a wrapping byte.
// - Location 0x03 shows comparator state; any write clears a latched output. The code keeps it set while the field is above threshold.
// - Location 0x04 gives the strap voltage caught at power-up.
// - Hysteresis at 0x21 defaults to 10; 255 forces latching.
// - Pull-up enable at 0x2a defaults to 1; 0 disables the pull-ups.
// - Magnet profile at 0x2b defaults 0: none, 1 ferrite, 2 rare-earth.
// - Locations 0x80-0x85 hold date code, rightmost character lowest.
// - Inversion parameter set flips the digital output polarity.
// - Filter output is sample/m plus (m-1)/m of previous; m 0 or 1 bypasses.
// - Field is raw times (1+temp*coef/100000) over gain minus offset.
// - Temperature is raw times 100 over slope plus temperature offset.
`ifndef MGM_DEFINES_VH
`define MGM_DEFINES_VH

// Memory locations.
`define MGM_A_CAL       8'h00
`define MGM_A_RAW       8'h01
`define MGM_A_TEMP      8'h02
`define MGM_A_CMP       8'h03
`define MGM_A_STRAPV    8'h04
`define MGM_A_RESTORE   8'h05
`define MGM_A_RESTORE2  8'h07
`define MGM_A_THR       8'h20
`define MGM_A_HYST      8'h21
`define MGM_A_INV       8'h22
`define MGM_A_FOFS      8'h23
`define MGM_A_FGAIN     8'h24
`define MGM_A_TCO       8'h25
`define MGM_A_TOFS      8'h26
`define MGM_A_TGAIN     8'h27
`define MGM_A_BUSADDR   8'h28
`define MGM_A_FILT      8'h29
`define MGM_A_PULL      8'h2a
`define MGM_A_PROF      8'h2b
`define MGM_A_LOT       8'h80
`define MGM_A_LOT_LAST  8'h85

// Factory values of the stored parameters.
`define MGM_D_THR       8'h64
`define MGM_D_HYST      8'h0a
`define MGM_D_INV       8'h00
`define MGM_D_FOFS      8'h00
`define MGM_D_FGAIN     8'h64
`define MGM_D_TCO       8'h64
`define MGM_D_TOFS      8'h00
`define MGM_D_TGAIN     8'h64
`define MGM_D_FILT      8'h01
`define MGM_D_PULL      8'h01
`define MGM_D_PROF      8'h00
`define MGM_NV_N        11

// Slave addresses and special values.
`define MGM_ADDR_OPEN   7'h48
`define MGM_ADDR_GND    7'h10
`define MGM_ADDR_MIN    7'h08
`define MGM_UNMAPPED    8'hff
`define MGM_LATCH_HYST  8'hff
`define MGM_RESTORE_VAL 8'h01
`define MGM_PROF_MAX    8'h02
`define MGM_FULL_BYTE   8'hff
`define MGM_PCT         100
`define MGM_PCT_W       16'd100
`define MGM_TC_SCALE    100000

`endif

// [design/mgm_nv_byte.v]
// One stored calibration byte with factory restore.
// Assumes writes and restore are single-cycle strobes from the core clock.
`timescale 1ns/10ps
module mgm_nv_byte #(
  parameter [7:0] DEFAULT = 8'h00     // Factory value.
) (
  input  wire       core_clk,         // System clock.
  input  wire       rstn,             // Asynchronous reset, active low.
  input  wire       wr_en,            // Store wr_data this cycle.
  input  wire       restore,          // Reload the factory value.
  input  wire [7:0] wr_data,          // Byte from the bus.
  output reg  [7:0] value_q           // Current parameter value.
);

  // Restore and a write never coincide, both come from one bus write.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      value_q <= DEFAULT;
    end else if (restore) begin
      value_q <= DEFAULT;
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end

endmodule // mgm_nv_byte

// [tb/mgm_master_model.sv]
// Bus master model driving the open-drain clock and data lines by tasks.
// Assumes the bench resolves the wire levels with a pull-up on each line.
`timescale 1ns/10ps
module mgm_master_model (
  input  wire  core_clk, // System clock.
  input  wire  sda_i,    // Resolved data level.
  output logic scl_r,    // 1 releases the clock line.
  output logic sda_r     // 1 releases the data line.
);
  // Quarter bit of 16 cycles gives 390 kHz, inside the bus limit.
  localparam int Q = 16;

  // Both lines start released.
  initial begin
    scl_r = 1'b1;
    sda_r = 1'b1;
  end

  // Lines only change just after a clock edge.
  task automatic qw();
    repeat (Q) @(posedge core_clk);
    #1;
  endtask

  // Every transfer begins here, also a repeated start.
  task automatic start();
    sda_r = 1'b1;
    qw();
    scl_r = 1'b1;
    qw();
    sda_r = 1'b0;
    qw();
    scl_r = 1'b0;
    qw();
  endtask

  // Stop, then a pause so a stored parameter may settle.
  task automatic stop();
    sda_r = 1'b0;
    qw();
    scl_r = 1'b1;
    qw();
    sda_r = 1'b1;
    repeat (4) qw();
  endtask

  // One bit: data set while the clock is low, sampled while high.
  task automatic bitx(input logic b, output logic r);
    sda_r = b;
    qw();
    scl_r = 1'b1;
    qw();
    r = sda_i;
    qw();
    scl_r = 1'b0;
    qw();
  endtask

  // A byte MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] tx, input logic ak,
                      output logic [7:0] rx, output logic ar);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(ak, ar);
  endtask
endmodule // mgm_master_model

// [tb/mgm_mem_map_assertions.sv]
// Checker on the ports of the memory map top module.
// Assumes it is bound to mgm_mem_map with one clock domain.
`timescale 1ns/10ps
module mgm_mem_map_assertions (
  input logic core_clk,   // System clock.
  input logic rstn,       // Reset, active low.
  input logic scl_i,      // Bus clock level.
  input logic scl_o,      // Clock drive value.
  input logic scl_oe,     // Clock drive enable.
  input logic sda_i,      // Bus data level.
  input logic sda_o,      // Data drive value.
  input logic sda_oe,     // Data drive enable.
  input logic sample_stb, // New sample strobe.
  input logic cmp_out,    // Comparator output.
  input logic pullup_en   // Pull-up enable.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] since_q;
  logic       frame_q;

  // Sample age bounds the comparator lag; frame flag spans start to stop.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      since_q <= 4'hf;
      frame_q <= 1'b0;
    end else begin
      if (sample_stb) since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
      if (scl_i && $past(scl_i) && $fell(sda_i)) frame_q <= 1'b1;
      else if (scl_i && $past(scl_i) && $rose(sda_i)) frame_q <= 1'b0;
    end
  end

  sequence s_oe_up;
    !sda_oe ##1 sda_oe;
  endsequence
  sequence s_start;
    scl_i && sda_i ##1 scl_i && !sda_i;
  endsequence

  AST_SCL_IDLE: assert property (!scl_oe && !scl_o)
    else $error("slave drives the bus clock");
  AST_SDA_OPEN_DRAIN: assert property (!sda_o)
    else $error("data drive value not low");
  AST_OE_IN_LOW: assert property ($changed(sda_oe) |-> !$past(scl_i))
    else $error("data drive changed while clock high");
  AST_OE_STANDS: assert property (s_oe_up |-> sda_oe [*8])
    else $error("data drive too short");
  AST_OE_IN_FRAME: assert property (sda_oe |-> frame_q)
    else $error("data driven outside a transfer");
  AST_START_FREE: assert property (s_start |-> !sda_oe)
    else $error("data driven at a start");
  AST_PULLUP_RESET: assert property ($rose(rstn) |-> pullup_en)
    else $error("pull-up enable not set after reset");
  AST_PULLUP_IN_ACK: assert property ($changed(pullup_en) |-> sda_oe)
    else $error("pull-up enable changed outside a data ack");
  AST_CMP_CAUSE: assert property ($changed(cmp_out) |->
    since_q < 4'h8 || sda_oe)
    else $error("output changed without sample or write");
endmodule // mgm_mem_map_assertions

// [tb/magnetometer_i2c_memory_map_tb.sv]
// Testbench for the memory map: a bus master model reads and writes it.
// Assumes the design and checker files are compiled before this one.
`timescale 1ns/10ps
module magnetometer_i2c_memory_map_tb;
  localparam logic [47:0] LOT = 48'h313233343536; // Arbitrary value.
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       strap_pin = 1'b1;
  logic [7:0] strap_level = 8'hd3;
  logic       sample_stb = 1'b0;
  logic [7:0] adc_field = 8'h00;
  logic [7:0] adc_temp = 8'h00;
  logic [6:0] dev_a = 7'h48;
  logic [7:0] rx;
  logic       ar;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  wire        scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe;
  wire        cmp_out, pullup_en, scl_r, sda_r;

  // 25 MHz system clock.
  always #20 core_clk = ~core_clk;
  // Open-drain wires: low if any party pulls, pulled up otherwise.
  assign scl_i = scl_r & ~(scl_oe & ~scl_o);
  assign sda_i = sda_r & ~(sda_oe & ~sda_o);

  mgm_mem_map #(.LOT_CODE(LOT)) i_dut (.core_clk(core_clk), .rstn(rstn),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .strap_pin(strap_pin),
    .strap_level(strap_level), .sample_stb(sample_stb),
    .adc_field(adc_field), .adc_temp(adc_temp), .cmp_out(cmp_out),
    .pullup_en(pullup_en));
  mgm_master_model i_mst (.core_clk(core_clk), .sda_i(sda_i),
    .scl_r(scl_r), .sda_r(sda_r));

  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // Byte sent by the master with the expected acknowledge level.
  task automatic put(input logic [7:0] b, input logic ea);
    i_mst.xfer(b, 1'b1, rx, ar);
    chk("ack", {7'h0, ea}, {7'h0, ar});
  endtask
  // Read one byte at the pointer and refuse further bytes.
  task automatic rd0(input logic [7:0] e);
    i_mst.start();
    put({dev_a, 1'b1}, 1'b0);
    i_mst.xfer(8'hff, 1'b1, rx, ar);
    chk("data", e, rx);
    i_mst.stop();
  endtask
  // Set the pointer, then read through a repeated start.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_mst.start();
    put({dev_a, 1'b0}, 1'b0);
    put(a, 1'b0);
    rd0(e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_mst.start();
    put({dev_a, 1'b0}, 1'b0);
    put(a, 1'b0);
    put(d, 1'b0);
    i_mst.stop();
  endtask
  task automatic smp(input logic [7:0] f, input logic [7:0] t);
    adc_field = f;
    adc_temp = t;
    sample_stb = 1'b1;
    @(posedge core_clk);
    #1;
    sample_stb = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  task automatic rst();
    rstn = 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic t_defaults();
    logic [7:0] a [14] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h21, 8'h22,
      8'h24, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h80, 8'h85};
    logic [7:0] e [14] = '{8'h32, 8'h00, 8'hd3, 8'hff, 8'h64, 8'h0a, 8'h00,
      8'h64, 8'h48, 8'h01, 8'h01, 8'h00, LOT[7:0], LOT[47:40]};
    smp(8'h32, 8'h00);
    rd0(8'h32);
    foreach (a[i]) rd(a[i], e[i]);
    rd0(LOT[47:40]);
  endtask
  task automatic t_temp();
    smp(8'h32, 8'h14);
    rd(8'h02, 8'h14);
    rd(8'h00, 8'h33);
  endtask
  // Chained pairs, with writes that must be ignored among them.
  task automatic t_chain();
    logic [7:0] w [18] = '{8'h20, 8'h50, 8'h20, 8'h00, 8'h21, 8'h05, 8'h10,
      8'h33, 8'h00, 8'h77, 8'h28, 8'h05, 8'h2b, 8'h01, 8'h2b, 8'h02, 8'h2b,
      8'h03};
    i_mst.start();
    put({dev_a, 1'b0}, 1'b0);
    foreach (w[i]) put(w[i], 1'b0);
    i_mst.stop();
    rd(8'h20, 8'h50);
    rd(8'h21, 8'h05);
    rd(8'h10, 8'hff);
    rd(8'h00, 8'h33);
    rd(8'h28, 8'h48);
    rd(8'h2b, 8'h02);
  endtask
  task automatic t_restore();
    wr(8'h05, 8'h01);
    rd(8'h20, 8'h64);
    rd(8'h21, 8'h0a);
    rd(8'h2b, 8'h00);
  endtask
  task automatic t_cmp();
    smp(8'h96, 8'h00);
    rd(8'h00, 8'h96);
    chk("cmp_out", 8'h01, {7'h0, cmp_out});
    smp(8'h00, 8'h00);
    chk("cmp_out", 8'h00, {7'h0, cmp_out});
    wr(8'h21, 8'hff);
    smp(8'h96, 8'h00);
    smp(8'h00, 8'h00);
    chk("cmp_out", 8'h01, {7'h0, cmp_out});
    rd(8'h03, 8'h01);
    wr(8'h03, 8'h00);
    chk("cmp_out", 8'h00, {7'h0, cmp_out});
    wr(8'h22, 8'h01);
    chk("cmp_out", 8'h01, {7'h0, cmp_out});
    wr(8'h2a, 8'h00);
    chk("pullup_en", 8'h00, {7'h0, pullup_en});
  endtask
  // Grounded strap at a second reset moves the slave address.
  task automatic t_strap();
    strap_pin = 1'b0;
    strap_level = 8'h00;
    rst();
    chk("pullup_en", 8'h01, {7'h0, pullup_en});
    i_mst.start();
    put({7'h48, 1'b0}, 1'b1);
    i_mst.stop();
    dev_a = 7'h10;
    rd(8'h04, 8'h00);
  endtask

  initial begin
    rst();
    t_defaults();
    t_temp();
    t_chain();
    t_restore();
    t_cmp();
    t_strap();
    give_verdict();
  end

  // Watchdog a little beyond the expected run of about 95000 cycles;
  // the bus rate cannot rise, so the margin stays small.
  initial begin
    repeat (99000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // magnetometer_i2c_memory_map_tb

bind mgm_mem_map mgm_mem_map_assertions i_chk (.core_clk(core_clk),
  .rstn(rstn), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .sample_stb(sample_stb),
  .cmp_out(cmp_out), .pullup_en(pullup_en));
